/* rtl/teg_timer_evt.v */
// Timer software event generator and channel 0/1 compare control
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "teg_consts.vh"
module teg_timer_evt #(
  parameter CNT_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [CNT_W-1:0] counter_value,
  input wire counter_tick,
  input wire count_down,
  input wire update_event_in,
  input wire [1:0] chan_active,
  input wire [1:0] chan_polarity,
  input wire ext_trigger_clear_signal,
  input wire own_filtered_input_a,
  input wire cross_filtered_input_a,
  input wire own_filtered_input_b,
  input wire cross_filtered_input_b,
  input wire internal_trigger_source,
  output wire counter_clear,
  output wire counter_reload,
  output wire prescaler_clear,
  output wire irq_request,
  output reg [5:0] dma_request,
  output wire [1:0] chan_reference_out,
  output reg [1:0] chan_pin_out,
  output reg [1:0] chan_capture_in
);

  // ----------------------------------------
  // Decoding and compare helpers
  // ----------------------------------------
  // Known register offset
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `TEG_OFF_INTEN) || (a == `TEG_OFF_STAT) ||
        (a == `TEG_OFF_SWEVG) || (a == `TEG_OFF_CTL0) ||
        (a == `TEG_OFF_CV0) || (a == `TEG_OFF_CV1);
    end
  endfunction

  // PWM mode 0 active level
  function pwm_active;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] cv;
    input down;
    begin
      if (down) begin
        pwm_active = (cnt <= cv);
      end else begin
        pwm_active = (cnt < cv);
      end
    end
  endfunction

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  reg aw_full_reg;
  reg [7:0] aw_addr_reg;
  reg w_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  wire wr_fire;
  wire wr_word;

  // Readies drop while the clock enable is low, so a master never
  // sees a handshake that the frozen state did not take
  assign s_axi_awready = clk_en & ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready = clk_en & ~w_full_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign wr_fire = clk_en & aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_word = wr_fire & (w_strb_reg == `TEG_STRB_ALL);

  // Holds address and data until both arrive
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      w_data_reg <= `TEG_ZERO32;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TEG_RESP_OK;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(aw_addr_reg) ? `TEG_RESP_OK : `TEG_RESP_ERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register write strobes, full-word writes only
  wire wr_inten = wr_word & (aw_addr_reg == `TEG_OFF_INTEN);
  wire wr_stat = wr_word & (aw_addr_reg == `TEG_OFF_STAT);
  wire wr_swevg = wr_word & (aw_addr_reg == `TEG_OFF_SWEVG);
  wire wr_ctl0 = wr_word & (aw_addr_reg == `TEG_OFF_CTL0);
  wire [1:0] wr_cv;
  assign wr_cv[0] = wr_word & (aw_addr_reg == `TEG_OFF_CV0);
  assign wr_cv[1] = wr_word & (aw_addr_reg == `TEG_OFF_CV1);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [31:0] inten_reg;
  reg [15:0] ctl_reg;
  reg [15:0] ctl_next;
  reg [6:0] gen_reg;
  integer k;

  // Select field locked while its channel is active
  // Other fields take the write even while the channel runs
  always @* begin
    ctl_next = ctl_reg;
    if (wr_ctl0) begin
      ctl_next = w_data_reg[15:0] & `TEG_CTL0_MASK;
      for (k = 0; k < 2; k = k + 1) begin
        if (chan_active[k]) begin
          ctl_next[k*`TEG_CH_STRIDE+`TEG_SEL_LSB +: 2] =
            ctl_reg[k*`TEG_CH_STRIDE+`TEG_SEL_LSB +: 2];
        end
      end
    end
  end

  // Generate bits live one cycle, then clear
  // Reads never see them, the read mux returns zero there
  always @(posedge aclk) begin
    if (!aresetn) begin
      inten_reg <= `TEG_ZERO32;
      ctl_reg <= 16'h0000;
      gen_reg <= 7'h00;
    end else if (clk_en) begin
      if (wr_inten) begin
        inten_reg <= w_data_reg & `TEG_INTEN_MASK;
      end
      ctl_reg <= ctl_next;
      gen_reg <= wr_swevg ? w_data_reg[6:0] : 7'h00;
    end
  end

  // Counter core actions of a software update
  assign counter_clear = gen_reg[`TEG_BIT_UPD] & ~count_down;
  assign counter_reload = gen_reg[`TEG_BIT_UPD] & count_down;
  assign prescaler_clear = gen_reg[`TEG_BIT_UPD];
  wire upd_any = update_event_in | gen_reg[`TEG_BIT_UPD];

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [12:0] stat_reg;
  wire [2*CNT_W-1:0] cv_bus;
  wire rd_fire = clk_en & s_axi_arvalid & ~rvalid_reg;
  reg [31:0] rd_mux;

  // Same clock enable gating as the write side
  assign s_axi_arready = clk_en & ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Read data selection, generate bits read zero
  always @* begin
    rd_mux = `TEG_ZERO32;
    case (s_axi_araddr)
      `TEG_OFF_INTEN: rd_mux = inten_reg;
      `TEG_OFF_STAT: rd_mux = {19'h0_0000, stat_reg};
      `TEG_OFF_CTL0: rd_mux = {16'h0000, ctl_reg};
      `TEG_OFF_CV0: rd_mux[CNT_W-1:0] = cv_bus[CNT_W-1:0];
      `TEG_OFF_CV1: rd_mux[CNT_W-1:0] = cv_bus[2*CNT_W-1:CNT_W];
      default: rd_mux = `TEG_ZERO32;
    endcase
  end

  // One read answered at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= `TEG_ZERO32;
      rresp_reg <= `TEG_RESP_OK;
    end else if (clk_en) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= is_mapped(s_axi_araddr) ? `TEG_RESP_OK : `TEG_RESP_ERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Channel 0 and 1 capture/compare
  // ----------------------------------------
  wire [1:0] cmp_evt;
  wire [1:0] cap_of;
  wire [1:0] rd_cv_clr;
  reg [1:0] ref_reg;
  wire [1:0] own_in = {own_filtered_input_b, own_filtered_input_a};
  wire [1:0] cross_in = {cross_filtered_input_b, cross_filtered_input_a};
  assign chan_reference_out = ref_reg;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : ch_g
      localparam B = ch * `TEG_CH_STRIDE;
      wire [1:0] sel = ctl_reg[B+`TEG_SEL_LSB +: 2];
      wire [2:0] mode = ctl_reg[B+`TEG_MODE_LSB +: 3];
      wire clr_en = ctl_reg[B+`TEG_CLREN_BIT];
      wire shadow_en = ctl_reg[B+`TEG_SHADOW_BIT];
      wire is_input = (sel != `TEG_SEL_OUT);
      wire sw_evt = gen_reg[ch+1];
      reg [CNT_W-1:0] cv_act_reg;
      reg [CNT_W-1:0] cv_shd_reg;
      reg ref_next;
      wire match = counter_tick & (counter_value == cv_act_reg);
      wire pwm0 = pwm_active(counter_value, cv_act_reg, count_down);

      assign cv_bus[ch*CNT_W +: CNT_W] = cv_act_reg;
      assign cmp_evt[ch] = ~is_input & match;
      assign cap_of[ch] = sw_evt & is_input & stat_reg[ch+1];
      assign rd_cv_clr[ch] = rd_fire & is_input &
        (s_axi_araddr == (ch == 0 ? `TEG_OFF_CV0 : `TEG_OFF_CV1));

      // Compare value, capture and shadow transfer
      // Input mode bypasses the shadow so captures land at once
      always @(posedge aclk) begin
        if (!aresetn) begin
          cv_act_reg <= {CNT_W{1'b0}};
          cv_shd_reg <= {CNT_W{1'b0}};
        end else if (clk_en) begin
          if (wr_cv[ch]) begin
            cv_shd_reg <= w_data_reg[CNT_W-1:0];
          end
          if (sw_evt && is_input) begin
            cv_act_reg <= counter_value;
          end else if (wr_cv[ch] && (!shadow_en || is_input)) begin
            cv_act_reg <= w_data_reg[CNT_W-1:0];
          end else if (shadow_en && upd_any && !is_input) begin
            cv_act_reg <= cv_shd_reg;
          end
        end
      end

      // Reference waveform by compare mode
      // Clear input overrides every mode, force high included
      always @* begin
        ref_next = ref_reg[ch];
        if (clr_en && ext_trigger_clear_signal) begin
          ref_next = 1'b0;
        end else begin
          case (mode)
            `TEG_MODE_FROZEN: ref_next = ref_reg[ch];
            `TEG_MODE_SET: if (match) ref_next = 1'b1;
            `TEG_MODE_CLR: if (match) ref_next = 1'b0;
            `TEG_MODE_TOG: if (match) ref_next = ~ref_reg[ch];
            `TEG_MODE_LOW: ref_next = 1'b0;
            `TEG_MODE_HIGH: ref_next = 1'b1;
            `TEG_MODE_PWM0: ref_next = pwm0;
            `TEG_MODE_PWM1: ref_next = ~pwm0;
            default: ref_next = ref_reg[ch];
          endcase
        end
      end

      // Reference, pin and capture source flops
      // Capture source reads zero while the channel is an output
      always @(posedge aclk) begin
        if (!aresetn) begin
          ref_reg[ch] <= 1'b0;
          chan_pin_out[ch] <= 1'b0;
          chan_capture_in[ch] <= 1'b0;
        end else if (clk_en) begin
          ref_reg[ch] <= ref_next;
          chan_pin_out[ch] <= ref_next ^ chan_polarity[ch];
          case (sel)
            `TEG_SEL_OWN: chan_capture_in[ch] <= own_in[ch];
            `TEG_SEL_CROSS: chan_capture_in[ch] <= cross_in[ch];
            `TEG_SEL_TRIG: chan_capture_in[ch] <= internal_trigger_source;
            default: chan_capture_in[ch] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Status flags, set wins over clear
  // ----------------------------------------
  reg [12:0] set_vec;
  reg [12:0] clr_vec;
  wire [5:0] evt6 = {gen_reg[`TEG_BIT_TRG], gen_reg[4:3],
    gen_reg[2:1] | cmp_evt, gen_reg[`TEG_BIT_UPD] | update_event_in};

  // Flag sources and software clears
  always @* begin
    set_vec = 13'h0000;
    clr_vec = 13'h0000;
    set_vec[4:0] = evt6[4:0];
    set_vec[`TEG_BIT_TRG] = evt6[5];
    set_vec[`TEG_OF_LSB +: 2] = cap_of;
    if (wr_stat) begin
      clr_vec = ~w_data_reg[12:0];
    end
    clr_vec[2:1] = clr_vec[2:1] | rd_cv_clr;
  end

  // Flag register, masked to the implemented bits
  // A hardware set in the cycle of a software clear wins, so an
  // event is never lost to a clear that raced it
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 13'h0000;
    end else if (clk_en) begin
      stat_reg <= ((stat_reg & ~clr_vec) | set_vec) & `TEG_STAT_MASK;
    end
  end

  // Interrupt level from enabled flags
  assign irq_request = |(stat_reg[6:0] & inten_reg[6:0]);

  // DMA request pulses per enabled event
  always @(posedge aclk) begin
    if (!aresetn) begin
      dma_request <= 6'h00;
    end else if (clk_en) begin
      dma_request <= evt6 & {inten_reg[`TEG_DEN_LSB+6],
        inten_reg[`TEG_DEN_LSB +: 5]};
    end
  end

endmodule

/* shared/teg_consts.vh */
// Constants for the timer event generator and compare control
`ifndef TEG_CONSTS_VH
`define TEG_CONSTS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define TEG_ADDR_W 8
`define TEG_OFF_INTEN 8'h0C
`define TEG_OFF_STAT 8'h10
`define TEG_OFF_SWEVG 8'h14
`define TEG_OFF_CTL0 8'h18
`define TEG_OFF_CV0 8'h34
`define TEG_OFF_CV1 8'h38
`define TEG_INTEN_MASK 32'h0000_5F5F
`define TEG_STAT_MASK 13'h1E5F
`define TEG_CTL0_MASK 16'hFBFB
`define TEG_ZERO32 32'h0000_0000
`define TEG_STRB_ALL 4'hF
`define TEG_RESP_OK 2'b00
`define TEG_RESP_ERR 2'b10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TEG_BIT_UPD 0
`define TEG_BIT_TRG 6
`define TEG_OF_LSB 9
`define TEG_DEN_LSB 8
`define TEG_CH_STRIDE 8
`define TEG_SEL_LSB 0
`define TEG_SHADOW_BIT 3
`define TEG_MODE_LSB 4
`define TEG_CLREN_BIT 7
// ----------------------------------------
// Select and compare mode encodings
// ----------------------------------------
`define TEG_SEL_OUT 2'b00
`define TEG_SEL_OWN 2'b01
`define TEG_SEL_CROSS 2'b10
`define TEG_SEL_TRIG 2'b11
`define TEG_MODE_FROZEN 3'b000
`define TEG_MODE_SET 3'b001
`define TEG_MODE_CLR 3'b010
`define TEG_MODE_TOG 3'b011
`define TEG_MODE_LOW 3'b100
`define TEG_MODE_HIGH 3'b101
`define TEG_MODE_PWM0 3'b110
`define TEG_MODE_PWM1 3'b111
`endif

/* sim/teg_core_model.sv */
// Model of the counter core beside the compare control
`timescale 1ns/1ps
module teg_core_model #(
  parameter int PERIOD = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic down,
  input wire logic counter_clear,
  input wire logic counter_reload,
  output logic [15:0] counter_value
);
  // Counter wrapping over PERIOD counts, up or down
  always @(posedge aclk) begin
    if (!aresetn || counter_clear) counter_value <= 16'h0000;
    else if (counter_reload || (run && down && counter_value == 16'h0000))
      counter_value <= 16'(PERIOD - 1);
    else if (run && down) counter_value <= counter_value - 16'h0001;
    else if (run) counter_value <= (counter_value == 16'(PERIOD - 1)) ? 16'h0000 : counter_value + 16'h0001;
  end
endmodule

/* sim/teg_timer_evt_monitor.sv */
// Checker on the ports of the timer event and compare block
`timescale 1ns/1ps
module teg_timer_evt_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic count_down,
  input wire logic counter_clear,
  input wire logic counter_reload,
  input wire logic prescaler_clear,
  input wire logic [1:0] chan_polarity,
  input wire logic [1:0] chan_reference_out,
  input wire logic [1:0] chan_pin_out
);
  logic [7:0] rd_addr_reg;
  // Address of the read in flight
  always @(posedge aclk) begin
    if (!aresetn) rd_addr_reg <= 8'h00;
    else if (clk_en && s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ref_pin_a: assert property (
    $past(aresetn) && $past(clk_en) |-> chan_pin_out == (chan_reference_out ^ $past(chan_polarity)))
    else $error("pin output differs from reference and polarity");
  upd_dir_a: assert property (
    prescaler_clear |-> counter_reload == count_down && counter_clear == !count_down)
    else $error("update event clears or reloads against direction");
  upd_prescale_a: assert property (
    counter_clear || counter_reload |-> prescaler_clear)
    else $error("prescaler not cleared with counter");
  upd_pulse_a: assert property (
    prescaler_clear && clk_en |=> !prescaler_clear)
    else $error("update generate did not clear itself");
  swevg_zero_a: assert property (
    s_axi_rvalid && rd_addr_reg == 8'h14 |-> s_axi_rdata == 32'h0000_0000)
    else $error("event generate register read nonzero");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready && clk_en |=> !s_axi_rvalid)
    else $error("read data held after handshake");
endmodule
bind teg_timer_evt teg_timer_evt_monitor teg_timer_evt_monitor_inst (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .count_down(count_down), .counter_clear(counter_clear),
  .counter_reload(counter_reload), .prescaler_clear(prescaler_clear),
  .chan_polarity(chan_polarity), .chan_reference_out(chan_reference_out),
  .chan_pin_out(chan_pin_out)
);

/* sim/test_timer_event_gen_and_compare_ctl.sv */
// Testbench for the timer event generator and compare control
`timescale 1ns/1ps
module test_timer_event_gen_and_compare_ctl;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, rd_data;
  logic run = 1'b0, down = 1'b0, ext_clr = 1'b0, seen_clr = 1'b0;
  logic [1:0] active = 2'b00, pol = 2'b00, rd_resp, wr_resp;
  logic [2:0] src = 3'h0;
  logic clk_en = 1'b1, upd_in = 1'b0;
  logic [8:0] seen = 9'h000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire clr, rld, psc, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp, ref_out, pin_out, cap_in;
  wire [31:0] s_axi_rdata;
  wire [15:0] cnt;
  wire [5:0] dma;
  int n_mismatch = 0, num_checks = 0, cyc = 0, hi, tog;

  teg_timer_evt teg_timer_evt_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .counter_value(cnt), .counter_tick(run), .count_down(down),
    .update_event_in(upd_in), .chan_active(active), .chan_polarity(pol),
    .ext_trigger_clear_signal(ext_clr), .own_filtered_input_a(src[0]),
    .cross_filtered_input_a(src[1]), .own_filtered_input_b(src[0]),
    .cross_filtered_input_b(src[1]), .internal_trigger_source(src[2]),
    .counter_clear(clr), .counter_reload(rld), .prescaler_clear(psc), .irq_request(irq),
    .dma_request(dma), .chan_reference_out(ref_out), .chan_pin_out(pin_out),
    .chan_capture_in(cap_in));
  teg_core_model #(.PERIOD(10)) teg_core_model_inst (.aclk(aclk), .aresetn(aresetn),
    .run(run), .down(down), .counter_clear(clr), .counter_reload(rld), .counter_value(cnt));

  // Clock, sticky record of pulses, and cycle limit
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) begin
    seen <= seen_clr ? 9'h000 : seen | {psc, rld, clr, dma};
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict;
    end
  end

  task chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    begin
      num_checks++;
      if (seen_v !== exp_v) begin
        n_mismatch++;
        $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
    end
  endtask

  task give_verdict;
    begin
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge aclk);
      seen_clr <= 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  // Set a compare mode, settle, then count high cycles and level changes
  task automatic meas(input logic [15:0] ctl);
    logic last;
    begin
      wr(8'h18, {16'h0000, ctl});
      repeat (12) @(posedge aclk);
      last = ref_out[0];
      hi = 0;
      tog = 0;
      repeat (40) begin
        @(posedge aclk);
        hi += ref_out[0];
        tog += (ref_out[0] != last);
        last = ref_out[0];
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h14);
    chk(rd_data, 32'h0000_0000);
    rd(8'h18);
    chk(rd_data, 32'h0000_0000);
    rd(8'h40);
    chk(rd_resp, 32'h0000_0002);
    wr(8'h40, 32'h0000_0000);
    chk(wr_resp, 32'h0000_0002);
    wr(8'h0C, 32'h0000_5F5F);
    chk(wr_resp, 32'h0000_0000);
    for (int i = 1; i <= 6; i++) begin
      if (i == 5) continue;
      wr(8'h10, 32'h0000_0000);
      seen_clr <= 1'b1;
      wr(8'h14, 32'h0000_0001 << i);
      repeat (2) @(posedge aclk);
      rd(8'h10);
      chk(rd_data, 32'h0000_0001 << i);
      chk(seen[(i == 6) ? 5 : i], 32'h0000_0001);
      chk(irq, 32'h0000_0001);
    end
    wr(8'h10, 32'h0000_0000);
    chk(irq, 32'h0000_0000);
    run <= 1'b1;
    repeat (7) @(posedge aclk);
    run <= 1'b0;
    wr(8'h18, 32'h0000_0101);
    wr(8'h10, 32'h0000_0000);
    wr(8'h14, 32'h0000_0002);
    wr(8'h14, 32'h0000_0002);
    rd(8'h10);
    chk(rd_data, 32'h0000_0202);
    rd(8'h34);
    chk(rd_data, {16'h0000, cnt});
    seen_clr <= 1'b1;
    wr(8'h14, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(seen[8:6], 32'h0000_0005);
    chk(cnt, 32'h0000_0000);
    down <= 1'b1;
    seen_clr <= 1'b1;
    wr(8'h14, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(seen[8:6], 32'h0000_0006);
    chk(cnt, 32'h0000_0009);
    down <= 1'b0;
    active <= 2'b11;
    wr(8'h18, 32'h0000_0303);
    rd(8'h18);
    chk(rd_data, 32'h0000_0101);
    active <= 2'b00;
    for (int k = 0; k < 4; k++) begin
      src <= (k == 0) ? 3'h7 : 3'h1 << (k - 1);
      wr(8'h18, k * 32'h0000_0101);
      rd(8'h18);
      chk(rd_data, k * 32'h0000_0101);
      chk(cap_in, (k == 0) ? 32'h0000_0000 : 32'h0000_0003);
      src <= ~src;
      repeat (3) @(posedge aclk);
      chk(cap_in, 32'h0000_0000);
    end
    wr(8'h18, 32'h0000_0000);
    wr(8'h34, 32'h0000_0003);
    run <= 1'b1;
    pol <= 2'b01;
    meas(16'h0040);
    chk(hi, 32'h0000_0000);
    meas(16'h0010);
    chk(hi, 32'h0000_0028);
    meas(16'h0000);
    chk(hi, 32'h0000_0028);
    meas(16'h0020);
    chk(hi, 32'h0000_0000);
    meas(16'h0030);
    chk(tog, 32'h0000_0004);
    meas(16'h0060);
    chk(hi, 32'h0000_000C);
    meas(16'h0070);
    chk(hi, 32'h0000_001C);
    down <= 1'b1;
    meas(16'h0060);
    chk(hi, 32'h0000_0010);
    meas(16'h0070);
    chk(hi, 32'h0000_0018);
    ext_clr <= 1'b1;
    meas(16'h00D0);
    chk(hi, 32'h0000_0000);
    ext_clr <= 1'b0;
    meas(16'h00D0);
    chk(hi, 32'h0000_0028);
    meas(16'h5040);
    chk(ref_out, 32'h0000_0002);
    // Shadowed compare value moves only on an enabled update event
    wr(8'h18, 32'h0000_0008);
    wr(8'h34, 32'h0000_0005);
    rd(8'h34);
    chk(rd_data, 32'h0000_0003);
    clk_en <= 1'b0;
    upd_in <= 1'b1;
    @(posedge aclk);
    upd_in <= 1'b0;
    @(posedge aclk);
    clk_en <= 1'b1;
    rd(8'h34);
    chk(rd_data, 32'h0000_0003);
    upd_in <= 1'b1;
    @(posedge aclk);
    upd_in <= 1'b0;
    rd(8'h34);
    chk(rd_data, 32'h0000_0005);
    give_verdict;
  end
endmodule
